// >>> hdl/hcp_pkg.sv
// Purpose : Shared constants and types of the host CPU port
// Assumes : One reference clock plus the host shift clock
// Notes   : Serial frame is rw bit, address, then data, MSB first

package hcp_pkg;

   // ----------------------------------------------------------------
   // Widths and reference clock
   // ----------------------------------------------------------------
   localparam int HCP_DW          = 8;            // Data bus width
   localparam int HCP_AW          = 8;            // Address bus width
   localparam int HCP_CTL_W       = 5;            // Mode, style, select, strobes
   localparam int HCP_REF_CLK_NS  = 5;            // Reference clock period

   // ----------------------------------------------------------------
   // Serial frame positions, counted in rising shift-clock edges
   // ----------------------------------------------------------------
   localparam int            HCP_SER_CNT_W  = 5;
   localparam logic [4:0]    HCP_SER_HDR_LAST = 5'h08;  // Last header bit
   localparam logic [4:0]    HCP_SER_WR_LAST  = 5'h10;  // Last write data bit
   localparam logic [4:0]    HCP_SER_RD_LOAD  = 5'h0b;  // First read data bit
   localparam logic [4:0]    HCP_SER_RD_LAST  = 5'h12;  // Last read data bit
   localparam logic [4:0]    HCP_SER_CNT_MAX  = 5'h1f;  // Counter saturates here

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]    HCP_RST_DATA  = 8'h00;
   localparam logic [4:0]    HCP_CTL_IDLE  = 5'h07;     // Select and strobes high

   // Parallel access sequencer
   typedef enum logic [3:0]
   {
      HCP_IDLE  = 4'h1,
      HCP_READ  = 4'h2,
      HCP_WRITE = 4'h4,
      HCP_DONE  = 4'h8
   } hcp_state_e;

endpackage

// >>> hdl/hcp_serial.sv
// Purpose : Shift-clocked serial engine of the host CPU port
// Assumes : Shift clock runs only while chip select is low
// Notes   : Chip select high clears the whole engine asynchronously

`timescale 1ns/1ps
`default_nettype none

module hcp_serial
   import hcp_pkg::*;
(
   input  wire logic              sclk,       // Host shift clock
   input  wire logic              cs_n,       // Chip select, active low
   input  wire logic              serial_en,  // Serial mode strap
   input  wire logic              serial_in_line, // Serial input line
   input  wire logic              edge_sel,   // Output edge select
   input  wire logic              ack,        // Read data ready, ref domain
   input  wire logic [HCP_DW-1:0] rdata,      // Read data, held under ack
   output logic                   req,        // Access request level
   output logic                   req_rw,     // High for a read
   output logic [HCP_AW-1:0]      req_addr,   // Access address
   output logic [HCP_DW-1:0]      req_wdata,  // Write data
   output logic                   serial_out_line // Serial output line
);

   logic [HCP_SER_CNT_W-1:0] cnt_r;
   logic [HCP_AW-1:0]        hdr_r;
   logic [HCP_DW-1:0]        wsh_r;
   logic [HCP_DW-1:0]        osh_r;
   logic                     ack_s1_r;
   logic                     ack_s2_r;
   logic                     sdo_p_r;
   logic                     sdo_n_r;

   // ----------------------------------------------------------------
   // Input shifting, all on rising edges
   // ----------------------------------------------------------------
   // Frame state cannot rely on a clock edge after the frame, so the
   // select line itself clears it
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         cnt_r     <= '0;
         hdr_r     <= '0;
         wsh_r     <= '0;
         req       <= 1'b0;
         req_rw    <= 1'b0;
         req_addr  <= '0;
         req_wdata <= '0;
      end
      else if (serial_en)
      begin
         if (cnt_r != HCP_SER_CNT_MAX)
            cnt_r <= cnt_r + 5'h01;
         if (cnt_r < HCP_SER_HDR_LAST)
            hdr_r <= {hdr_r[HCP_AW-2:0], serial_in_line};
         if (cnt_r == HCP_SER_HDR_LAST)
         begin
            req_rw   <= hdr_r[HCP_AW-1];
            req_addr <= {hdr_r[HCP_AW-2:0], serial_in_line};
            req      <= hdr_r[HCP_AW-1];
         end
         if (cnt_r > HCP_SER_HDR_LAST && cnt_r <= HCP_SER_WR_LAST)
            wsh_r <= {wsh_r[HCP_DW-2:0], serial_in_line};
         if (cnt_r == HCP_SER_WR_LAST && !req_rw)
         begin
            req_wdata <= {wsh_r[HCP_DW-2:0], serial_in_line};
            req       <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data return and output shifting
   // ----------------------------------------------------------------
   // Ack passes two flops here; the turnaround bits give it time
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         osh_r    <= HCP_RST_DATA;
         sdo_p_r  <= 1'b0;
      end
      else
      begin
         ack_s1_r <= ack;
         ack_s2_r <= ack_s1_r;
         if (serial_en && req_rw && cnt_r == HCP_SER_RD_LOAD)
         begin
            // Without an answer in time the host reads zeros
            osh_r   <= ack_s2_r ? {rdata[HCP_DW-2:0], 1'b0} : HCP_RST_DATA;
            sdo_p_r <= ack_s2_r & rdata[HCP_DW-1];
         end
         else if (serial_en && req_rw && cnt_r > HCP_SER_RD_LOAD &&
                  cnt_r <= HCP_SER_RD_LAST)
         begin
            osh_r   <= {osh_r[HCP_DW-2:0], 1'b0};
            sdo_p_r <= osh_r[HCP_DW-1];
         end
         else
            sdo_p_r <= 1'b0;
      end
   end

   // Falling-edge copy, half a shift clock behind
   always_ff @(negedge sclk or posedge cs_n)
   begin
      if (cs_n)
         sdo_n_r <= 1'b0;
      else
         sdo_n_r <= sdo_p_r;
   end

   // Edge select picks one of two flops; it is a strap, not a clock mux
   assign serial_out_line = edge_sel ? sdo_n_r : sdo_p_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   ser_count_a: assert property (@(posedge sclk) disable iff (cs_n)
      (serial_en && cnt_r < HCP_SER_WR_LAST) |=> cnt_r == $past(cnt_r) + 5'h01)
      else $error("serial bit counter skipped an edge");

   ser_out_a: assert property (@(posedge sclk) disable iff (cs_n)
      (serial_en && req_rw && cnt_r > HCP_SER_RD_LOAD && cnt_r <= HCP_SER_RD_LAST)
      |=> sdo_p_r == $past(osh_r[HCP_DW-1]))
      else $error("serial output bit out of order");

   ser_read_c: cover property (@(posedge sclk) disable iff (cs_n)
      req_rw && cnt_r == HCP_SER_RD_LAST && ack_s2_r);

endmodule

`default_nettype wire

// >>> hdl/hcp_top.sv
// Purpose : Host CPU port: serial and two parallel bus styles
// Assumes : Host pins are asynchronous to REF_CLK; straps are static
// Notes   : Register file sits outside on the REG_ ports

`timescale 1ns/1ps
`default_nettype none

module hcp_top
   import hcp_pkg::*;
#(
   parameter int DATA_W = HCP_DW,                   // Data bus width
   parameter int ADDR_W = HCP_AW                    // Address bus width
)
(
   input  wire logic              REF_CLK,          // Reference clock
   input  wire logic              RST_N,            // Sync reset, active low
   input  wire logic              SCLK,             // Host shift clock
   input  wire logic              PAR_SEL,          // High parallel, low serial
   input  wire logic              BUS_STYLE_SELECT, // Parallel bus style
   input  wire logic              CS_N,             // Chip select
   input  wire logic              DATA_STROBE_N,    // Data or read strobe
   input  wire logic              DIR_WR_N,         // Direction or write strobe
   input  wire logic [ADDR_W-1:0] ADDR,             // Address bus
   input  wire logic [DATA_W-1:0] D_IN,             // Data bus, in
   output logic      [DATA_W-1:0] D_OUT,            // Data bus, out
   output logic                   D_OE,             // Data bus drive enable
   input  wire logic              SERIAL_IN_LINE,   // Serial data in
   input  wire logic              OUTPUT_EDGE_SELECT, // Serial out edge
   output logic                   SERIAL_OUT_LINE,  // Serial data out
   output logic      [ADDR_W-1:0] REG_ADDR,         // Register address
   output logic      [DATA_W-1:0] REG_WDATA,        // Register write data
   output logic                   REG_WR,           // Write pulse
   output logic                   REG_RD,           // Read pulse
   input  wire logic [DATA_W-1:0] REG_RDATA         // Read data for REG_ADDR
);
   import hcp_pkg::*;

   localparam int PIN_W = HCP_CTL_W + ADDR_W + DATA_W;
   localparam logic [PIN_W-1:0] PIN_IDLE = {HCP_CTL_IDLE, {(ADDR_W+DATA_W){1'b0}}};

   // The serial frame is byte wide, so the buses must be too
   if (DATA_W != HCP_DW || ADDR_W != HCP_AW)
   begin : g_width_check
      $error("hcp_top supports only 8-bit address and data");
   end

   // A bit takes its new value once the 2nd and 3rd stages agree
   function automatic logic [PIN_W-1:0] settle_f(input logic [PIN_W-1:0] s2,
                                                 input logic [PIN_W-1:0] s3,
                                                 input logic [PIN_W-1:0] held);
      return (s2 & s3) | (held & (s2 ^ s3));
   endfunction

   logic [PIN_W-1:0]  pin_raw;
   logic [PIN_W-1:0]  pin_s1_r;
   logic [PIN_W-1:0]  pin_s2_r;
   logic [PIN_W-1:0]  pin_s3_r;
   logic [PIN_W-1:0]  pin_f_r;
   logic              par_f;
   logic              style_f;
   logic              cs_n_f;
   logic              data_strobe_n_f;
   logic              rw_f;
   logic [ADDR_W-1:0] addr_f;
   logic [DATA_W-1:0] data_f;
   logic              rd_req;
   logic              wr_req;
   logic              cs_n_d_r;
   logic              armed_r;
   hcp_state_e        st_r;
   hcp_state_e        st_nxt;
   logic              rd_valid_r;
   logic [ADDR_W-1:0] par_addr_r;
   logic [DATA_W-1:0] par_wdata_r;
   logic              par_rd_go;
   logic              par_wr_go;
   logic              ser_req;
   logic              ser_rw;
   logic [ADDR_W-1:0] ser_addr;
   logic [DATA_W-1:0] ser_wdata;
   logic [2:0]        ser_req_s_r;
   logic              ser_req_f_r;
   logic              ser_req_d_r;
   logic              ser_go;
   logic              ser_cap_r;
   logic              ser_ack_r;
   logic [DATA_W-1:0] ser_rdata_r;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   assign pin_raw = {PAR_SEL, BUS_STYLE_SELECT, CS_N, DATA_STROBE_N, DIR_WR_N, ADDR, D_IN};

   // Three stages against metastability; filtered copy rejects one-stage glitches
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         pin_s1_r <= PIN_IDLE;
         pin_s2_r <= PIN_IDLE;
         pin_s3_r <= PIN_IDLE;
         pin_f_r  <= PIN_IDLE;
      end
      else
      begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_f_r  <= settle_f(pin_s2_r, pin_s3_r, pin_f_r);
      end
   end

   assign par_f   = pin_f_r[PIN_W-1];
   assign style_f = pin_f_r[PIN_W-2];
   assign cs_n_f  = pin_f_r[PIN_W-3];
   assign data_strobe_n_f = pin_f_r[PIN_W-4];
   assign rw_f    = pin_f_r[PIN_W-5];
   assign addr_f  = pin_f_r[ADDR_W+DATA_W-1:DATA_W];
   assign data_f  = pin_f_r[DATA_W-1:0];

   // Strobe decode per bus style; with both strobes low a read wins
   assign rd_req = style_f ? !data_strobe_n_f
                           : (!data_strobe_n_f && rw_f);
   assign wr_req = style_f ? (data_strobe_n_f && !rw_f)
                           : (!data_strobe_n_f && !rw_f);

   // ----------------------------------------------------------------
   // Select arming
   // ----------------------------------------------------------------
   // Each access needs a fresh falling select edge
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         cs_n_d_r <= 1'b1;
         armed_r  <= 1'b0;
      end
      else
      begin
         cs_n_d_r <= cs_n_f;
         if (cs_n_f)
            armed_r <= 1'b0;
         else if (cs_n_d_r)
            armed_r <= 1'b1;
         else if (st_r == HCP_IDLE && st_nxt != HCP_IDLE)
            armed_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Parallel access sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         HCP_IDLE:
            if (par_f && !cs_n_f && armed_r && rd_req)
               st_nxt = HCP_READ;
            else if (par_f && !cs_n_f && armed_r && wr_req)
               st_nxt = HCP_WRITE;
         HCP_READ:
            if (cs_n_f || !rd_req)
               st_nxt = HCP_DONE;
         HCP_WRITE:
            if (cs_n_f || !wr_req)
               st_nxt = HCP_DONE;
         HCP_DONE:
            if (!rd_req && !wr_req)
               st_nxt = HCP_IDLE;
         default:
            st_nxt = HCP_IDLE;
      endcase
   end

   assign par_rd_go = (st_r == HCP_IDLE) && (st_nxt == HCP_READ);
   assign par_wr_go = (st_r == HCP_WRITE) && (st_nxt == HCP_DONE);

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         st_r <= HCP_IDLE;
      else
         st_r <= st_nxt;
   end

   // Address held from access start; write data follows the bus under the strobe
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         par_addr_r  <= '0;
         par_wdata_r <= HCP_RST_DATA;
      end
      else
      begin
         if (st_r == HCP_IDLE)
            par_addr_r <= addr_f;
         if (st_r == HCP_WRITE && wr_req)
            par_wdata_r <= data_f;
      end
   end

   // Data bus drive; sync lag keeps the driver on up to 5 cycles past select rise
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         rd_valid_r <= 1'b0;
         D_OUT      <= HCP_RST_DATA;
         D_OE       <= 1'b0;
      end
      else
      begin
         rd_valid_r <= (st_r == HCP_READ) && (st_nxt == HCP_READ);
         if (st_r == HCP_READ && !rd_valid_r)
            D_OUT <= REG_RDATA;
         D_OE <= (st_r == HCP_READ) && (st_nxt == HCP_READ);
      end
   end

   // ----------------------------------------------------------------
   // Serial engine and its crossing
   // ----------------------------------------------------------------
   hcp_serial u_serial
   (
      .sclk      (SCLK),
      .cs_n      (CS_N),
      .serial_en (!PAR_SEL),
      .serial_in_line (SERIAL_IN_LINE),
      .edge_sel  (OUTPUT_EDGE_SELECT),
      .ack       (ser_ack_r),
      .rdata     (ser_rdata_r),
      .req       (ser_req),
      .req_rw    (ser_rw),
      .req_addr  (ser_addr),
      .req_wdata (ser_wdata),
      .serial_out_line (SERIAL_OUT_LINE)
   );

   // Request level crosses in three stages; words stay still while it is high
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         ser_req_s_r <= '0;
         ser_req_f_r <= 1'b0;
         ser_req_d_r <= 1'b0;
         ser_cap_r   <= 1'b0;
         ser_ack_r   <= 1'b0;
         ser_rdata_r <= HCP_RST_DATA;
      end
      else
      begin
         ser_req_s_r <= {ser_req_s_r[1:0], ser_req};
         if (ser_req_s_r[1] == ser_req_s_r[2])
            ser_req_f_r <= ser_req_s_r[1];
         ser_req_d_r <= ser_req_f_r;
         ser_cap_r   <= ser_go && ser_rw;
         if (ser_cap_r)
            ser_rdata_r <= REG_RDATA;
         if (!ser_req_f_r)
            ser_ack_r <= 1'b0;
         else if (ser_cap_r)
            ser_ack_r <= 1'b1;
      end
   end

   assign ser_go = ser_req_f_r && !ser_req_d_r && !par_f;

   // ----------------------------------------------------------------
   // Register file port
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         REG_ADDR  <= '0;
         REG_WDATA <= HCP_RST_DATA;
         REG_WR    <= 1'b0;
         REG_RD    <= 1'b0;
      end
      else
      begin
         REG_RD <= par_rd_go || (ser_go && ser_rw);
         REG_WR <= par_wr_go || (ser_go && !ser_rw);
         if (par_rd_go)
            REG_ADDR <= addr_f;
         else if (par_wr_go)
         begin
            REG_ADDR  <= par_addr_r;
            REG_WDATA <= par_wdata_r;
         end
         else if (ser_go)
         begin
            REG_ADDR  <= ser_addr;
            REG_WDATA <= ser_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   start_cs_a: assert property ((st_r == HCP_IDLE && st_nxt != HCP_IDLE)
      |-> (!cs_n_f && armed_r && par_f))
      else $error("parallel access began without select");

   arm_edge_a: assert property ($rose(armed_r) |-> $past(cs_n_f, 2) && !$past(cs_n_f))
      else $error("armed without falling select");

   rd_strobe_a: assert property ((REG_RD && par_f && !style_f)
      |-> $past(!data_strobe_n_f && rw_f))
      else $error("strobe-direction read without its strobe");

   rd_sep_a: assert property ((REG_RD && par_f && style_f) |-> $past(!data_strobe_n_f))
      else $error("read-strobe read without its strobe");

   wr_strobe_a: assert property ((REG_WR && par_f)
      |-> $past(st_r == HCP_WRITE) && REG_WDATA == $past(par_wdata_r))
      else $error("parallel write did not carry captured data");

   wr_sep_a: assert property ((st_r == HCP_WRITE && wr_req && style_f)
      |=> par_wdata_r == $past(data_f))
      else $error("write strobe data not captured");

   rd_first_a: assert property ((par_f && style_f && st_r == HCP_IDLE && armed_r
      && !cs_n_f && !data_strobe_n_f) |=> st_r == HCP_READ)
      else $error("read strobe did not start a read");

   oe_read_a: assert property (D_OE |-> $past(!cs_n_f && rd_req && st_r == HCP_READ))
      else $error("data bus driven outside a selected read");

   oe_data_a: assert property ((st_r == HCP_READ && !rd_valid_r && st_nxt == HCP_READ)
      |=> D_OE && D_OUT == $past(REG_RDATA))
      else $error("read data not driven on the bus");

   ser_ack_a: assert property ($rose(ser_req_f_r) && !par_f
      |-> ##[2:3] ser_ack_r || !ser_rw)
      else $error("serial read not answered");

   par_read_c:  cover property (par_rd_go && !style_f ##[1:20] D_OE);
   par_write_c: cover property (par_wr_go && style_f);
   ser_write_c: cover property (ser_go && !ser_rw);

endmodule

`default_nettype wire

// >>> verification/hcp_host_model.sv
// Purpose : Host microcontroller model for the host port pins
// Assumes : REF_CLK paces parallel cycles; the shift clock is made here
// Notes   : Shift clock stands still low between frames
`timescale 1ns/1ps
`default_nettype none
module hcp_host_model
   import hcp_pkg::*;
(
   input  wire logic              clk,   // Reference clock
   output logic                   sclk,  // Shift clock
   output logic                   cs_n,  // Chip select
   output logic                   data_strobe_n, // Data or read strobe
   output logic                   dw_n,  // Direction or write strobe
   output logic      [HCP_AW-1:0] addr,  // Address
   output logic      [HCP_DW-1:0] d_in,  // Data wire level
   input  wire logic [HCP_DW-1:0] d_out, // Port read data
   input  wire logic              d_oe,  // Port drives the wire
   output logic                   serial_in_line,  // Serial data in
   input  wire logic              serial_out_line, // Serial data out
   output logic                   hung   // A bounded wait ran out
);
   logic [HCP_DW-1:0] hd;  // Host data value
   logic              hoe; // Host drives the wire
   // Released wire shows the inverse of the last host value, never a stale copy
   assign d_in = d_oe ? d_out : (hoe ? hd : ~hd);
   initial
   begin
      {sclk, serial_in_line, hd, hoe, hung, addr} = '0;
      {cs_n, data_strobe_n, dw_n} = 3'h7;
   end
   // ----------------------------------------------------------------
   // Parallel access; sel low leaves chip select high on purpose
   // ----------------------------------------------------------------
   task automatic par(input logic sty, input logic rd, input logic sel,
                      input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rdv);
      int i;
      i = 0;
      @(posedge clk);
      cs_n <= !sel;
      addr <= a;
      hd <= wd;
      hoe <= !rd;
      dw_n <= sty | rd;
      repeat (2) @(posedge clk);
      if (sty && !rd)
         dw_n <= 1'b0;
      else
         data_strobe_n <= 1'b0;
      if (!rd)
         repeat (8) @(posedge clk);
      while (rd && d_oe !== 1'b1 && i < 40)
      begin
         @(posedge clk);
         i++;
      end
      rdv = d_out;
      data_strobe_n <= 1'b1;
      if (sty)
         dw_n <= 1'b1;
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      hoe <= 1'b0;
      while (d_oe !== 1'b0 && i < 40)
      begin
         @(posedge clk);
         i++;
      end
      repeat (6) @(posedge clk);
      if (i >= 40)
         hung <= 1'b1;
   endtask
   // Serial frame: rw, address, then write data or turnaround and read data
   task automatic ser(input logic rd, input logic es, input logic [7:0] a,
                      input logic [7:0] wd, output logic [7:0] rdv);
      logic [16:0] fr;
      fr = {rd, a, wd};
      rdv = '0;
      cs_n <= 1'b0;
      #20;
      for (int k = 1; k <= (rd ? 20 : 17); k++)
      begin
         serial_in_line <= (k <= 17) ? fr[17-k] : 1'b0;
         #24 sclk = 1'b1;
         if (es && k >= 13)
            rdv = {rdv[6:0], serial_out_line};
         #24 sclk = 1'b0;
         if (!es && k >= 12 && k <= 19)
            rdv = {rdv[6:0], serial_out_line};
      end
      #20 cs_n <= 1'b1;
      serial_in_line <= ~serial_in_line;
      #60;
   endtask
endmodule
`default_nettype wire

// >>> verification/test_host_cpu_port.sv
// Purpose : Self-checking bench of the host CPU port
// Assumes : Register file stand-in answers addr xor 5a at once
// Notes   : Register strobes are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module test_host_cpu_port;
   import hcp_pkg::*;
   logic ref_clk, rst_n, par_sel, style, esel, hung;
   logic sclk, cs_n, data_strobe_n, dw_n, d_oe, serial_in_line, serial_out_line, reg_wr, reg_rd;
   logic [7:0] addr, d_in, d_out, reg_addr, reg_wdata, reg_rdata, a, wd, rdv;
   logic [16:0] exp_q[$];
   logic [31:0] xs;
   int mismatches, n_checks;
   assign reg_rdata = reg_addr ^ 8'h5a; // Combinational register file
   hcp_top uut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCLK(sclk), .PAR_SEL(par_sel),
      .BUS_STYLE_SELECT(style), .CS_N(cs_n), .DATA_STROBE_N(data_strobe_n), .DIR_WR_N(dw_n),
      .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
      .SERIAL_IN_LINE(serial_in_line), .OUTPUT_EDGE_SELECT(esel),
      .SERIAL_OUT_LINE(serial_out_line), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
   hcp_host_model host (.clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .data_strobe_n(data_strobe_n),
      .dw_n(dw_n), .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
      .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .hung(hung));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [16:0] seen, input logic [16:0] expv);
      n_checks++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Any strobe without a pending note is a stray access
   // Looked at mid-cycle, where the registered strobes have settled
   always @(negedge ref_clk)
      if (reg_wr === 1'b1 || reg_rd === 1'b1)
         check({reg_rd, reg_addr, reg_rd ? 8'h00 : reg_wdata},
               exp_q.size() ? exp_q.pop_front() : 17'h1ffff);
   always @(posedge hung)
   begin
      mismatches++;
      report_and_stop;
   end
   // ----------------------------------------------------------------
   // Main sequence: two parallel styles, two serial output edges
   // ----------------------------------------------------------------
   initial
   begin
      {rst_n, style, esel, mismatches, n_checks} = '0;
      par_sel = 1'b1;
      xs = 32'd55;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         par_sel <= (m < 2);
         style <= m[0];
         esel <= m[0];
         repeat (8) @(posedge ref_clk);
         for (int j = 0; j < 3; j++)
         begin
            xs = xorshift(xs);
            a = xs[7:0];
            wd = xs[15:8];
            exp_q.push_back({1'b0, a, wd});
            exp_q.push_back({1'b1, a, 8'h00});
            if (m < 2)
            begin
               host.par(style, 1'b0, 1'b1, a, wd, rdv);
               host.par(style, 1'b1, 1'b1, a, wd, rdv);
            end
            else
            begin
               host.ser(1'b0, esel, a, wd, rdv);
               host.ser(1'b1, esel, a, wd, rdv);
            end
            check({9'h0, rdv}, {9'h0, a ^ 8'h5a});
            check({16'h0, d_oe}, 17'h0);
         end
      end
      // Write strobe with select held high must leave no trace
      par_sel <= 1'b1;
      style <= 1'b0;
      repeat (8) @(posedge ref_clk);
      host.par(1'b0, 1'b0, 1'b0, 8'h3c, 8'ha5, rdv);
      repeat (20) @(posedge ref_clk);
      check({16'h0, d_oe}, 17'h0);
      check(17'(exp_q.size()), 17'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
